// >>> design/asp_map.svh
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ASP_OFS_CTRL    8'h00
`define ASP_OFS_FRAME   8'h04
`define ASP_OFS_DIV     8'h08
`define ASP_OFS_STAT    8'h0C
`define ASP_OFS_MASK    8'h10
`define ASP_OFS_LIVE    8'h14
// ---------------------------------------------------------------
// control, frame and status fields
// ---------------------------------------------------------------
`define ASP_CTRL_EN     0
`define ASP_CTRL_MODE   3:1
`define ASP_CTRL_WLEN   8:4
`define ASP_CTRL_LSBF   9
`define ASP_CTRL_ICLK   10
`define ASP_CTRL_IFS    11
`define ASP_CTRL_DIR0   12
`define ASP_CTRL_CMP0   15:14
`define ASP_CTRL_CMP1   17:16
`define ASP_CTRL_CMPL   14
`define ASP_FRAME_SLOTS 6:0
`define ASP_FRAME_FLEN  20:8
`define ASP_ST_FSERR    0
`define ASP_ST_UNDER    1
`define ASP_ST_OVER     2
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ASP_RST_CTRL    32'h0000_00F0
`define ASP_RST_FRAME   32'h0000_1F00
`define ASP_RST_DIV     16'h0001
// ---------------------------------------------------------------
// timing and word length minima
// ---------------------------------------------------------------
`define ASP_CLK_NS      25
`define ASP_MIN_BIT_NS  20
`define ASP_MIN_HALF    ((`ASP_MIN_BIT_NS + 2*`ASP_CLK_NS - 1) / (2*`ASP_CLK_NS))
`define ASP_MIN_WL_STD  5'd2
`define ASP_MIN_WL_LR   5'd7
`endif

// >>> design/asp_pkg.sv
package asp_pkg;
   typedef enum logic [2:0] {ASP_STD, ASP_TDM, ASP_I2S, ASP_PI2S, ASP_LJ}
      asp_mode_t;
   typedef logic [31:0] asp_word_t;
   typedef logic [1:0][31:0] asp_pair_t;
endpackage : asp_pkg

// >>> design/asp_port.sv
`timescale 1ns/100ps
`include "asp_map.svh"
// Contract
// - port pins: two data lines, one bit clock, one frame sync
// - each line transmit or receive, with its own dma word channel
// - bit rate at most 50 Mbps; partner clocks no faster
// - two ports pair for tdm: one transmits both lines, other receives
// - tdm frames carry up to 128 slots
// - modes: standard, tdm, i2s, packed i2s, left-justified pair
// - left-justified: one sample on fs high, one on fs low
// - i2s/left-justified on both lines gives four channels
// - bit order per word selectable, lsb or msb first
// - standard and tdm word length 3 to 32 bits
// - i2s and left-justified word length 8 to 32 bits
// - optional mu-law or a-law companding chosen per data line
// - bit clock and frame sync internal or driven by partner
// - frame sync during a word in flight is an error
// - frame sync errors share one error interrupt
// - eight ports give sixteen pins, up to 32 channels
module asp_port
   import asp_pkg::*;
(
   input  wire logic             core_clk,   // 40 MHz
   input  wire logic             rstn,       // sync reset, low
   input  wire logic [7:0]       paddr,      // apb address
   input  wire logic             psel,       // apb select
   input  wire logic             penable,    // apb enable
   input  wire logic             pwrite,     // apb direction
   input  wire asp_pkg::asp_word_t pwdata,   // apb write data
   output asp_pkg::asp_word_t    prdata,     // apb read data
   output logic                  pready,     // apb ready
   output logic                  pslverr,    // apb error
   output logic                  irq,        // error interrupt
   input  wire logic             sclk_in,    // bit clock pin in
   output logic                  sclk_out,   // bit clock pin out
   output logic                  sclk_oe,    // bit clock drive
   input  wire logic             fs_in,      // frame sync pin in
   output logic                  fs_out,     // frame sync pin out
   output logic                  fs_oe,      // frame sync drive
   input  wire logic [1:0]       din,        // data pins in
   output logic [1:0]            dout,       // data pins out
   output logic [1:0]            dout_oe,    // data pin drive
   input  wire asp_pkg::asp_pair_t tx_data,  // dma words to send
   input  wire logic [1:0]       tx_valid,   // dma word offered
   output logic [1:0]            tx_ready,   // holding slot free
   output asp_pkg::asp_pair_t    rx_data,    // dma received words
   output logic [1:0]            rx_valid,   // received word held
   input  wire logic [1:0]       rx_ready    // dma takes word
);
   import asp_pkg::*;

   // ------------------------------------------------------------
   // companding and bit order helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] asp_enc(input logic [15:0] lin,
                                          input logic alaw);
      logic       sgn;
      logic [15:0] mag;
      logic [2:0] seg;
      logic [3:0] man;
      sgn = lin[15];
      mag = {1'b0, (sgn ? ~lin[14:0] : lin[14:0])};
      if (!alaw)
         mag = (mag > 16'h7F7B) ? 16'h7FFF : mag + 16'h0084;
      seg = 3'h0;
      for (int i = 0; i < 7; i++)
         if (mag[i + 8])
            seg = 3'(i + 1);
      man = 4'(mag >> (5'(seg) + 5'h03));
      return alaw ? ({~sgn, seg, man} ^ 8'h55) : ~{sgn, seg, man};
   endfunction : asp_enc

   function automatic logic [15:0] asp_dec(input logic [7:0] code,
                                           input logic alaw);
      logic [7:0]  c;
      logic [15:0] mag;
      c = alaw ? (code ^ 8'h55) : ~code;
      mag = 16'({1'b1, c[3:0], 1'b1}) << (5'(c[6:4]) + 5'h02);
      if (!alaw)
         mag = mag - 16'h0084;
      return c[7] ? ~mag : mag;
   endfunction : asp_dec

   function automatic logic [4:0] asp_bitpos(input logic [4:0] cnt,
                                             input logic [4:0] wl,
                                             input logic lsbf);
      return lsbf ? cnt : wl - cnt;
   endfunction : asp_bitpos

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] ctrl, frame, next_ctrl, next_frame;
   logic [15:0] div, next_div;
   logic [2:0]  stat, mask, next_stat, next_mask;
   asp_word_t   next_prdata;
   logic        next_pslverr;
   logic [3:0]  in_s1, in_s2;
   logic        sclk_d, fs_prev, next_sclk_d, next_fs_prev;
   logic [15:0] div_cnt, next_div_cnt;
   logic        sclk_gen, fs_gen, next_sclk_gen, next_fs_gen;
   logic [12:0] fcnt, next_fcnt;
   logic [1:0]  arm, next_arm;
   logic        active, more, next_active, next_more;
   logic [4:0]  bcnt, next_bcnt;
   logic [6:0]  slot, next_slot;
   asp_pair_t   tx_sh, tx_buf, rx_sh, next_tx_sh, next_tx_buf, next_rx_sh;
   asp_pair_t   next_rx_data;
   logic [1:0]  tx_full, next_tx_full, next_rx_valid, next_dout;

   // decoded configuration
   asp_mode_t   mode;
   logic        en, lr, sclk_lvl, fs_lvl, rise, fall, start, load;
   logic [4:0]  wl;
   logic [1:0]  dirtx;
   logic [2:0]  set;
   logic        setup, wr;

   always_comb
   begin
      en    = ctrl[`ASP_CTRL_EN];
      dirtx = ctrl[`ASP_CTRL_DIR0 + 1:`ASP_CTRL_DIR0];
      // five modes; spare codes fall back to standard
      unique case (ctrl[`ASP_CTRL_MODE])
         3'h1:    mode = ASP_TDM;
         3'h2:    mode = ASP_I2S;
         3'h3:    mode = ASP_PI2S;
         3'h4:    mode = ASP_LJ;
         default: mode = ASP_STD;
      endcase
      lr = (mode == ASP_I2S) || (mode == ASP_PI2S) || (mode == ASP_LJ);
      wl = ctrl[`ASP_CTRL_WLEN];
      if (lr && wl < `ASP_MIN_WL_LR)
         wl = `ASP_MIN_WL_LR;
      else if (!lr && wl < `ASP_MIN_WL_STD)
         wl = `ASP_MIN_WL_STD;
      // internal or partner clock and frame sync
      sclk_lvl = ctrl[`ASP_CTRL_ICLK] ? sclk_gen : in_s2[0];
      fs_lvl   = ctrl[`ASP_CTRL_IFS] ? fs_gen : in_s2[1];
      rise  = en & sclk_lvl & ~sclk_d;
      fall  = en & ~sclk_lvl & sclk_d;
      // lr modes frame on either fs level change
      start = lr ? (fs_lvl != fs_prev) : (fs_lvl & ~fs_prev);
      load  = fall & ((arm == 2'h1) | more);
      setup = psel & ~penable;
      wr    = psel & penable & pwrite;
   end

   // ------------------------------------------------------------
   // serial engine
   // ------------------------------------------------------------
   always_comb
   begin
      next_sclk_d   = sclk_lvl;
      next_fs_prev  = fs_prev;
      next_div_cnt  = div_cnt;
      next_sclk_gen = sclk_gen;
      next_fcnt     = fcnt;
      next_fs_gen   = fs_gen;
      next_arm      = arm;
      next_active   = active;
      next_more     = more;
      next_bcnt     = bcnt;
      next_slot     = slot;
      next_tx_sh    = tx_sh;
      next_tx_buf   = tx_buf;
      next_tx_full  = tx_full;
      next_rx_sh    = rx_sh;
      next_rx_data  = rx_data;
      next_rx_valid = rx_valid;
      next_dout     = dout;
      set           = 3'h0;
      // half period floor keeps the bit rate legal
      if (!en || div_cnt >= div || div_cnt >= 16'hFFFE)
      begin
         next_div_cnt  = 16'h0000;
         next_sclk_gen = en & ~sclk_gen;
      end
      else
         next_div_cnt = div_cnt + 16'h0001;
      if (fall)
      begin
         next_fcnt = (fcnt >= frame[`ASP_FRAME_FLEN]) ? 13'h0000
                                                      : fcnt + 13'h0001;
         // lr modes: fs high for first half, low for second
         next_fs_gen = lr ? (next_fcnt <= (frame[`ASP_FRAME_FLEN] >> 1))
                          : (next_fcnt == 13'h0000);
      end
      for (int l = 0; l < 2; l++)
      begin
         // dma side: one holding word per line
         if (tx_valid[l] && !tx_full[l])
         begin
            next_tx_buf[l]  = tx_data[l];
            next_tx_full[l] = 1'b1;
         end
         if (rx_valid[l] && rx_ready[l])
            next_rx_valid[l] = 1'b0;
      end
      if (rise)
      begin
         next_fs_prev = fs_lvl;
         if (start)
         begin
            // fs while a word is in flight
            if (active || more)
               set[`ASP_ST_FSERR] = 1'b1;
            next_arm    = (mode == ASP_I2S || mode == ASP_PI2S) ? 2'h2
                                                                 : 2'h1;
            next_active = 1'b0;
            next_more   = 1'b0;
            next_slot   = 7'h00;
         end
         else if (active)
         begin
            for (int l = 0; l < 2; l++)
               next_rx_sh[l][asp_bitpos(bcnt, wl, ctrl[`ASP_CTRL_LSBF])]
                  = in_s2[l + 2];
            next_bcnt = bcnt + 5'h01;
            if (bcnt == wl)
            begin
               next_active = 1'b0;
               for (int l = 0; l < 2; l++)
               begin
                  if (!dirtx[l])
                  begin
                     next_rx_data[l] = next_rx_sh[l];
                     if (ctrl[`ASP_CTRL_CMPL + 2*l +: 2] != 2'h0)
                        next_rx_data[l] = 32'(signed'(asp_dec(
                           next_rx_sh[l][7:0],
                           ctrl[`ASP_CTRL_CMPL + 2*l + 1])));
                     if (rx_valid[l] && !rx_ready[l])
                        set[`ASP_ST_OVER] = 1'b1;
                     next_rx_valid[l] = 1'b1;
                  end
               end
               // tdm and packed i2s walk up to 128 slots
               if ((mode == ASP_TDM || mode == ASP_PI2S)
                   && slot < frame[`ASP_FRAME_SLOTS])
               begin
                  next_more = 1'b1;
                  next_slot = slot + 7'h01;
               end
            end
         end
      end
      if (fall && arm != 2'h0)
         next_arm = arm - 2'h1;
      if (load)
      begin
         next_active = 1'b1;
         next_more   = 1'b0;
         next_bcnt   = 5'h00;
         for (int l = 0; l < 2; l++)
         begin
            next_tx_sh[l] = 32'h0000_0000;
            if (dirtx[l])
            begin
               if (tx_full[l])
               begin
                  next_tx_sh[l]   = tx_buf[l];
                  next_tx_full[l] = 1'b0;
               end
               else
                  set[`ASP_ST_UNDER] = 1'b1;
               if (ctrl[`ASP_CTRL_CMPL + 2*l +: 2] != 2'h0)
                  next_tx_sh[l] = {24'h00_0000, asp_enc(
                     next_tx_sh[l][15:0], ctrl[`ASP_CTRL_CMPL + 2*l + 1])};
            end
            next_dout[l] = next_tx_sh[l][asp_bitpos(5'h00, wl,
                                                    ctrl[`ASP_CTRL_LSBF])];
         end
      end
      else if (fall && active)
      begin
         for (int l = 0; l < 2; l++)
            next_dout[l] = tx_sh[l][asp_bitpos(bcnt, wl,
                                               ctrl[`ASP_CTRL_LSBF])];
      end
      if (!en)
      begin
         next_arm    = 2'h0;
         next_active = 1'b0;
         next_more   = 1'b0;
         next_fcnt   = 13'h0000;
         next_fs_gen = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // apb registers
   // ------------------------------------------------------------
   always_comb
   begin
      next_ctrl    = ctrl;
      next_frame   = frame;
      next_div     = div;
      next_mask    = mask;
      next_stat    = stat;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      if (wr)
      begin
         unique case (paddr)
            `ASP_OFS_CTRL:  next_ctrl  = pwdata & 32'h0003_FFFF;
            `ASP_OFS_FRAME: next_frame = pwdata & 32'h001F_FF7F;
            `ASP_OFS_DIV:   next_div   = (pwdata[15:0] < 16'(`ASP_MIN_HALF))
                                         ? 16'(`ASP_MIN_HALF) : pwdata[15:0];
            `ASP_OFS_MASK:  next_mask  = pwdata[2:0];
            `ASP_OFS_STAT:  next_stat  = stat & ~pwdata[2:0];
            default:        next_stat  = stat;
         endcase
      end
      // set wins over a one-written clear
      next_stat = next_stat | set;
      if (setup)
      begin
         next_pslverr = 1'b0;
         unique case (paddr)
            `ASP_OFS_CTRL:  next_prdata = ctrl;
            `ASP_OFS_FRAME: next_prdata = frame;
            `ASP_OFS_DIV:   next_prdata = {16'h0000, div};
            `ASP_OFS_STAT:  next_prdata = {29'h0, stat};
            `ASP_OFS_MASK:  next_prdata = {29'h0, mask};
            `ASP_OFS_LIVE:  next_prdata = {14'h0000, rx_valid, tx_full,
                                           slot, bcnt, more, active};
            default:
            begin
               next_prdata  = 32'h0000_0000;
               next_pslverr = 1'b1;
            end
         endcase
      end
      else if (psel && penable)
         next_pslverr = pslverr;
   end

   always_ff @(posedge core_clk)
   begin
      // only the second stage is read by logic
      in_s1 <= {din, fs_in, sclk_in};
      in_s2 <= in_s1;
      if (!rstn)
      begin
         ctrl     <= `ASP_RST_CTRL;
         frame    <= `ASP_RST_FRAME;
         div      <= `ASP_RST_DIV;
         stat     <= 3'h0;
         mask     <= 3'h0;
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'b0;
         sclk_d   <= 1'b0;
         fs_prev  <= 1'b0;
         div_cnt  <= 16'h0000;
         sclk_gen <= 1'b0;
         fs_gen   <= 1'b0;
         fcnt     <= 13'h0000;
         arm      <= 2'h0;
         active   <= 1'b0;
         more     <= 1'b0;
         bcnt     <= 5'h00;
         slot     <= 7'h00;
         tx_sh    <= '0;
         tx_buf   <= '0;
         tx_full  <= 2'h0;
         rx_sh    <= '0;
         rx_data  <= '0;
         rx_valid <= 2'h0;
         dout     <= 2'h0;
      end
      else
      begin
         ctrl     <= next_ctrl;
         frame    <= next_frame;
         div      <= next_div;
         stat     <= next_stat;
         mask     <= next_mask;
         prdata   <= next_prdata;
         pslverr  <= next_pslverr;
         sclk_d   <= next_sclk_d;
         fs_prev  <= next_fs_prev;
         div_cnt  <= next_div_cnt;
         sclk_gen <= next_sclk_gen;
         fs_gen   <= next_fs_gen;
         fcnt     <= next_fcnt;
         arm      <= next_arm;
         active   <= next_active;
         more     <= next_more;
         bcnt     <= next_bcnt;
         slot     <= next_slot;
         tx_sh    <= next_tx_sh;
         tx_buf   <= next_tx_buf;
         tx_full  <= next_tx_full;
         rx_sh    <= next_rx_sh;
         rx_data  <= next_rx_data;
         rx_valid <= next_rx_valid;
         dout     <= next_dout;
      end
   end

   // ------------------------------------------------------------
   // pins and handshakes
   // ------------------------------------------------------------
   always_comb
   begin
      pready   = 1'b1;
      // port error feeds the shared interrupt line
      irq      = |(stat & mask);
      tx_ready = ~tx_full;
      // drive clock and sync only when generated here
      sclk_out = sclk_gen;
      sclk_oe  = en & ctrl[`ASP_CTRL_ICLK];
      fs_out   = fs_gen;
      fs_oe    = en & ctrl[`ASP_CTRL_IFS];
      // each line drives only when set to transmit
      dout_oe  = {2{en}} & dirtx;
   end
endmodule : asp_port

// >>> tb/asp_codec.sv
`timescale 1ns/100ps
// ----------------------------------------
// external codec owning clock and sync
// ----------------------------------------
module asp_codec
(
   output logic      sclk,  // bit clock to port
   output logic      fs,    // frame sync to port
   output logic      dtx,   // data towards port
   input  wire logic drx    // data from port
);
   int half = 100;

   initial
   begin
      sclk = 1'h0;
      fs = 1'h0;
      dtx = 1'h0;
   end

   // partner clock, bit of 2*half ns (200 ns at the default half of 100), idle low between frames
   task automatic frame(input logic [31:0] w, input int nb,
                        output logic [31:0] r);
      r = 32'h0;
      // keep pin edges off the core clock edge
      #(5);
      fs = 1'h1;
      #(half) sclk = 1'h1;
      #(half) sclk = 1'h0;
      fs = 1'h0;
      for (int i = nb - 1; i >= 0; i--)
      begin
         dtx = w[i];
         #(half) sclk = 1'h1;
         r = {r[30:0], drx};
         #(half) sclk = 1'h0;
      end
      // released line must not keep showing the last bit
      dtx = ~dtx;
   endtask : frame
endmodule : asp_codec

// >>> tb/asp_properties.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checks for the serial audio port
// ----------------------------------------
module asp_properties
   import asp_pkg::*;
(
   input wire logic               core_clk,  // clock
   input wire logic               rstn,      // sync reset, low
   input wire logic               psel,      // apb select
   input wire logic               penable,   // apb enable
   input wire logic               pwrite,    // apb direction
   input wire asp_pkg::asp_word_t prdata,    // apb read data
   input wire logic               pready,    // apb ready
   input wire logic               pslverr,   // apb error
   input wire logic               irq,       // error interrupt
   input wire logic               sclk_out,  // bit clock out
   input wire logic               sclk_oe,   // bit clock drive
   input wire logic [1:0]         dout_oe,   // data pin drive
   input wire logic [1:0]         tx_valid,  // dma offer
   input wire logic [1:0]         tx_ready,  // holding free
   input wire logic [1:0]         rx_valid,  // word held
   input wire logic [1:0]         rx_ready   // dma takes
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_setup_access;
      psel && !penable ##1 psel && penable;
   endsequence

   chk_apb_answer: assert property (s_setup_access |-> pready)
      else $error("no ready in access phase");
   chk_refused_zero: assert property (
      psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused read returned data");
   chk_reset_quiet: assert property (disable iff (1'b0)
      !rstn |=> !irq && !sclk_oe && dout_oe == 2'h0 && tx_ready == 2'h3
         && rx_valid == 2'h0)
      else $error("outputs not quiet after reset");
   chk_tx_take: assert property (
      tx_valid[1] && tx_ready[1] |=> !tx_ready[1])
      else $error("holding slot still free after take");
   chk_rx_hold: assert property (
      rx_valid[0] && !rx_ready[0] |=> rx_valid[0])
      else $error("received word dropped before take");
   chk_sclk_rate: assert property (
      sclk_oe && $changed(sclk_out) |=> $stable(sclk_out) || !sclk_oe)
      else $error("bit clock toggles too fast");
   chk_oe_by_write: assert property (
      $changed({sclk_oe, dout_oe}) |-> $past(psel && penable && pwrite))
      else $error("pin drive changed without a write");
   chk_irq_clear: assert property (
      $fell(irq) |-> $past(psel && penable && pwrite))
      else $error("interrupt fell without a write");
endmodule : asp_properties

bind asp_port asp_properties u_props (
   .core_clk, .rstn, .psel, .penable, .pwrite, .prdata, .pready,
   .pslverr, .irq, .sclk_out, .sclk_oe, .dout_oe, .tx_valid,
   .tx_ready, .rx_valid, .rx_ready
);

// >>> tb/audio_serial_port_tb_top.sv
`timescale 1ns/100ps
`include "asp_map.svh"
// ----------------------------------------
// bench: apb and dma tasks, codec partner
// ----------------------------------------
module audio_serial_port_tb_top;
   import asp_pkg::*;
   logic       core_clk, rstn, psel, penable, pwrite, e, sclk_w, fs_w;
   logic       pready, pslverr, irq, sclk_out, sclk_oe, fs_out, fs_oe;
   logic       c_sclk, c_fs, c_d;
   logic [7:0] paddr;
   logic [1:0] dout, dout_oe, tx_valid, tx_ready, rx_valid, rx_ready, dw;
   asp_word_t  pwdata, prdata, q, r, v;
   asp_pair_t  tx_data, rx_data;
   int         err_total = 0;
   int         n_tests = 0;
   int         cyc = 0;
   int         t_nb[4] = '{8, 8, 3, 32};
   asp_word_t  t_ctl[4] = '{32'h2071, 32'h2271, 32'h2021, 32'h21F1};
   asp_word_t  t_tx[4] = '{32'hA5, 32'h35, 32'h6, 32'h1234_5678};
   asp_word_t  t_cs[4] = '{32'h3C, 32'h12, 32'h3, 32'h8765_4321};
   asp_word_t  t_get[4] = '{32'hA5, 32'hAC, 32'h6, 32'h1234_5678};
   asp_word_t  t_rx[4] = '{32'h3C, 32'h48, 32'h3, 32'h8765_4321};
   asp_word_t  t_m[4] = '{32'hFF, 32'hFF, 32'h7, 32'hFFFF_FFFF};

   // each pin level resolved from the port's drive enable alone
   assign sclk_w = sclk_oe ? sclk_out : c_sclk;
   assign fs_w = fs_oe ? fs_out : c_fs;
   assign dw[0] = dout_oe[0] ? dout[0] : c_d;
   assign dw[1] = dout_oe[1] ? dout[1] : cyc[0];

   asp_port dut (
      .core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
      .fs_in(fs_w), .fs_out(fs_out), .fs_oe(fs_oe), .din(dw),
      .dout(dout), .dout_oe(dout_oe), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready));

   asp_codec codec (.sclk(c_sclk), .fs(c_fs), .dtx(c_d), .drx(dw[1]));

   initial
   begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   // a hang ends the run through the same report
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input asp_word_t d);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1)
         @(posedge core_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input asp_word_t d);
      apb(1'h1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input asp_word_t x);
      apb(1'h0, a, 32'h0);
      chk(q, x);
   endtask : rd

   task automatic give(input asp_word_t w);
      @(posedge core_clk);
      tx_data[1] <= w;
      tx_valid[1] <= 1'h1;
      @(posedge core_clk);
      while (tx_ready[1] !== 1'h1)
         @(posedge core_clk);
      tx_valid[1] <= 1'h0;
   endtask : give

   task automatic take(input asp_word_t x, input asp_word_t m);
      int n = 0;
      @(posedge core_clk);
      while (rx_valid[0] !== 1'h1 && n < 400)
      begin
         @(posedge core_clk);
         n++;
      end
      chk(rx_data[0] & m, x);
      rx_ready[0] <= 1'h1;
      @(posedge core_clk);
      rx_ready[0] <= 1'h0;
   endtask : take

   initial
   begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      tx_data = '0;
      tx_valid = 2'h0;
      rx_ready = 2'h0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'h1;
      rd(`ASP_OFS_CTRL, `ASP_RST_CTRL);
      rd(`ASP_OFS_FRAME, `ASP_RST_FRAME);
      rd(`ASP_OFS_DIV, {16'h0, `ASP_RST_DIV});
      rd(`ASP_OFS_STAT, 32'h0);
      rd(`ASP_OFS_MASK, 32'h0);
      apb(1'h0, 8'h18, 32'h0);
      chk({q[30:0], e}, 32'h1);
      for (int m = 0; m < 5; m++)
      begin
         v = 32'h70;
         v[3:1] = 3'(m);
         v[15:14] = 2'(m);
         v[17:16] = ~2'(m);
         wr(`ASP_OFS_CTRL, v);
         rd(`ASP_OFS_CTRL, v);
      end
      // last word is 32 bits at a slow partner clock
      for (int i = 0; i < 4; i++)
      begin
         codec.half = (i == 3) ? 300 : 100;
         wr(`ASP_OFS_CTRL, t_ctl[i]);
         give(t_tx[i]);
         codec.frame(t_cs[i], t_nb[i], r);
         chk(r, t_get[i]);
         take(t_rx[i], t_m[i]);
      end
      codec.half = 100;
      wr(`ASP_OFS_CTRL, 32'h2071);
      wr(`ASP_OFS_MASK, 32'h1);
      codec.frame(32'h0, 3, r);
      codec.frame(32'h0, 8, r);
      apb(1'h0, `ASP_OFS_STAT, 32'h0);
      chk(q & 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(`ASP_OFS_MASK, 32'h0);
      #1 chk({31'h0, irq}, 32'h0);
      wr(`ASP_OFS_STAT, 32'h0);
      apb(1'h0, `ASP_OFS_STAT, 32'h0);
      chk(q & 32'h1, 32'h1);
      wr(`ASP_OFS_MASK, 32'h1);
      #1 chk({31'h0, irq}, 32'h1);
      wr(`ASP_OFS_STAT, 32'h1);
      #1 chk({31'h0, irq}, 32'h0);
      apb(1'h0, `ASP_OFS_STAT, 32'h0);
      chk(q & 32'h1, 32'h0);
      wr(`ASP_OFS_CTRL, 32'h2C71);
      repeat (60) @(posedge core_clk);
      chk({30'h0, sclk_oe, fs_oe}, 32'h3);
      wr(`ASP_OFS_CTRL, 32'h0);
      print_verdict();
   end
endmodule : audio_serial_port_tb_top
